// >>> hdl/euhp_map.svh
// Constants for the energy front end host serial port
`ifndef EUHP_MAP_SVH
`define EUHP_MAP_SVH

// ----------------------------------------------------------------
// Clocks and baud generation
// ----------------------------------------------------------------
`define EUHP_CLK_KHZ      20000
`define EUHP_CLK_NS       50
`define EUHP_MCLK_KHZ     4096
`define EUHP_BAUD_SCALE   524288
`define EUHP_OVERSAMPLE   16
`define EUHP_HALF_BIT     8
`define EUHP_DIV_DEFAULT  16'h004D
`define EUHP_DIV_MAX      16'hFFFF

// ----------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------
`define EUHP_DATA_BITS    8
`define EUHP_FRAME_BITS   10

// ----------------------------------------------------------------
// Reset pin timing
// ----------------------------------------------------------------
`define EUHP_RST_HOLD_NS  120000
`define EUHP_RST_HOLD_CYC \
  ((`EUHP_RST_HOLD_NS + `EUHP_CLK_NS - 1) / `EUHP_CLK_NS)
`define EUHP_INIT_CYC     16

// ----------------------------------------------------------------
// Configuration reset values
// ----------------------------------------------------------------
`define EUHP_GAIN_DEFAULT 1'h0
`define EUHP_DOFN_DEFAULT 2'h0

`endif

// >>> hdl/euhp_pkg.sv
// Types and shared arithmetic for the host serial port
package euhp_pkg;

  typedef enum logic [3:0] {
    EUHP_LN_IDLE  = 4'h1,
    EUHP_LN_START = 4'h2,
    EUHP_LN_DATA  = 4'h4,
    EUHP_LN_STOP  = 4'h8
  } euhp_line_t;

  typedef enum logic [2:0] {
    EUHP_DV_RUN  = 3'h1,
    EUHP_DV_HOLD = 3'h2,
    EUHP_DV_INIT = 3'h4
  } euhp_dev_t;

  typedef enum logic [0:0] {
    EUHP_GAIN_10X = 1'h0,
    EUHP_GAIN_50X = 1'h1
  } euhp_gain_t;

  typedef enum logic [1:0] {
    EUHP_DO_ENERGY = 2'h0,
    EUHP_DO_IRQ    = 2'h1,
    EUHP_DO_ZCROSS = 2'h2,
    EUHP_DO_DIR    = 2'h3
  } euhp_dofn_t;

  // Fractional step: returns {tick, next accumulator}
  function automatic logic [40:0] euhp_nco_step(
    input logic [39:0] acc,
    input logic [15:0] div,
    input logic [39:0] mclk_khz,
    input logic [39:0] clk_khz
  );
    logic [39:0] inc;
    logic [39:0] modulus;
    logic [39:0] sum;
    inc     = 40'({24'h0, div}) * 40'(16) * mclk_khz;
    modulus = 40'(524288) * clk_khz;
    sum     = acc + inc;
    if (sum >= modulus) begin
      euhp_nco_step = {1'b1, sum - modulus};
    end else begin
      euhp_nco_step = {1'b0, sum};
    end
  endfunction

endpackage

// >>> hdl/euhp_link_if.sv
// Two-wire link and reset pin between device and host
`timescale 1ns/1ps
`default_nettype none

interface euhp_link_if;
  logic tx_line;
  logic rx_line;
  logic reset_pin_n;

  modport device (
    output tx_line,
    input  rx_line,
    input  reset_pin_n
  );

  modport host (
    input  tx_line,
    output rx_line,
    output reset_pin_n
  );
endinterface

`default_nettype wire

// >>> hdl/euhp_device.sv
// Device end of the host serial port with reset and configuration
`timescale 1ns/1ps
`default_nettype none
`include "euhp_map.svh"

// Overview of operation
// - Ten bit periods: start, eight data, stop
// - Data bits go least significant first
// - Independent receive and transmit, no clock line
// - Rate is divisor times master clock over 524288
// - Default rate 600 baud at 4.096 MHz
// - Top rate 512K baud at 4.096 MHz
// - Device drives transmit, host drives receive
// - Reset pin low over 120 us clears all but mclk_ext_out
// - Release starts init loading default values
// - Current gain selectable 10x or 50x
// - Digital output selects pulse, irq, zero, direction
// - Master clock from crystal or external source
module euhp_device
  import euhp_pkg::*;
#(
  parameter int MCLK_KHZ = `EUHP_MCLK_KHZ,
  parameter int CLK_KHZ  = `EUHP_CLK_KHZ
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  // Link
  euhp_link_if.device      link,
  // Configuration
  input  wire logic        cfg_load_in,
  input  wire logic [15:0] baud_div_in,
  input  wire logic        gain_sel_in,
  input  wire logic [1:0]  do_func_in,
  input  wire logic        mclk_ext_in,
  // Transmit stream
  input  wire logic [7:0]  tx_data_in,
  input  wire logic        tx_valid_in,
  output logic             tx_ready_out,
  // Receive stream
  output logic [7:0]       rx_data_out,
  output logic             rx_valid_out,
  output logic             rx_frame_err_out,
  // Measurement events for the digital output
  input  wire logic        energy_pulse_in,
  input  wire logic        irq_in,
  input  wire logic        zero_cross_in,
  input  wire logic        energy_dir_in,
  // Status and configuration outputs
  output logic             do_out,
  output logic             gain_50x_out,
  output logic             mclk_ext_out,
  output logic             running_out
);

  // ----------------------------------------------------------------
  // Reset pin supervision
  // ----------------------------------------------------------------
  logic        rpin_s1;
  logic        rpin_s2;
  logic [11:0] hold_cnt;
  logic [4:0]  init_cnt;
  euhp_dev_t   dev_state;
  logic        core_rst;

  always_ff @(posedge clk_in) begin
    rpin_s1 <= link.reset_pin_n;
    rpin_s2 <= rpin_s1;
  end

  always_ff @(posedge clk_in) begin
    if (reset_in || rpin_s2) begin
      hold_cnt <= 12'h000;
    end else if (hold_cnt != 12'(`EUHP_RST_HOLD_CYC)) begin
      hold_cnt <= hold_cnt + 12'h001;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      dev_state <= EUHP_DV_INIT;
      init_cnt  <= 5'h00;
    end else begin
      case (dev_state)
        EUHP_DV_RUN: begin
          if (hold_cnt == 12'(`EUHP_RST_HOLD_CYC)) begin
            dev_state <= EUHP_DV_HOLD;
          end
        end
        EUHP_DV_HOLD: begin
          init_cnt <= 5'h00;
          if (rpin_s2) begin
            dev_state <= EUHP_DV_INIT;
          end
        end
        EUHP_DV_INIT: begin
          init_cnt <= init_cnt + 5'h01;
          if (init_cnt == 5'(`EUHP_INIT_CYC - 1)) begin
            dev_state <= EUHP_DV_RUN;
          end
        end
        default: dev_state <= EUHP_DV_INIT;
      endcase
    end
  end

  assign core_rst = (dev_state != EUHP_DV_RUN);

  always_ff @(posedge clk_in) begin
    running_out <= !reset_in && !core_rst;
  end

  // ----------------------------------------------------------------
  // Configuration, defaults loaded during init
  // ----------------------------------------------------------------
  logic [15:0] baud_div;
  euhp_dofn_t  do_func;

  always_ff @(posedge clk_in) begin
    if (reset_in || core_rst) begin
      baud_div     <= `EUHP_DIV_DEFAULT;
      gain_50x_out <= `EUHP_GAIN_DEFAULT;
      do_func      <= euhp_dofn_t'(`EUHP_DOFN_DEFAULT);
    end else if (cfg_load_in) begin
      // Zero would stall the link forever, so it is refused
      if (baud_div_in != 16'h0000) begin
        baud_div <= baud_div_in;
      end
      gain_50x_out <= gain_sel_in;
      do_func      <= euhp_dofn_t'(do_func_in);
    end
  end

  // Clock source is a strap caught after release
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      mclk_ext_out <= 1'b0;
    end else if (dev_state == EUHP_DV_INIT) begin
      mclk_ext_out <= mclk_ext_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in || core_rst) begin
      do_out <= 1'b0;
    end else begin
      case (do_func)
        EUHP_DO_ENERGY: do_out <= energy_pulse_in;
        EUHP_DO_IRQ:    do_out <= irq_in;
        EUHP_DO_ZCROSS: do_out <= zero_cross_in;
        EUHP_DO_DIR:    do_out <= energy_dir_in;
        default:        do_out <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Oversampling tick
  // ----------------------------------------------------------------
  logic [39:0] nco_acc;
  logic [40:0] nco_nxt;
  logic        tick;

  assign nco_nxt = euhp_nco_step(nco_acc, baud_div, 40'(MCLK_KHZ),
                                 40'(CLK_KHZ));

  always_ff @(posedge clk_in) begin
    if (reset_in || core_rst) begin
      nco_acc <= 40'h0;
      tick    <= 1'b0;
    end else begin
      nco_acc <= nco_nxt[39:0];
      tick    <= nco_nxt[40];
    end
  end

  // ----------------------------------------------------------------
  // Transmitter, runs beside the receiver
  // ----------------------------------------------------------------
  euhp_line_t tx_state;
  logic [3:0] tx_os;
  logic [2:0] tx_bit;
  logic [7:0] tx_shift;
  logic       tx_take;

  assign tx_take = tx_valid_in && tx_ready_out;

  always_ff @(posedge clk_in) begin
    if (reset_in || core_rst) begin
      tx_state     <= EUHP_LN_IDLE;
      tx_os        <= 4'h0;
      tx_bit       <= 3'h0;
      tx_shift     <= 8'h00;
      link.tx_line <= 1'b1;
      tx_ready_out <= 1'b0;
    end else begin
      tx_ready_out <= (tx_state == EUHP_LN_IDLE) && !tx_take;
      if (tx_state != EUHP_LN_IDLE && tick) begin
        tx_os <= tx_os + 4'h1;
      end
      case (tx_state)
        EUHP_LN_IDLE: begin
          link.tx_line <= 1'b1;
          if (tx_take) begin
            tx_shift <= tx_data_in;
            tx_bit   <= 3'h1;
            tx_state <= EUHP_LN_START;
          end
        end
        EUHP_LN_START: begin
          // Start edge waits for a tick so the start bit is full length
          if (tick && tx_bit == 3'h1) begin
            link.tx_line <= 1'b0;
            tx_os        <= 4'h0;
            tx_bit       <= 3'h0;
          end else if (tick && tx_os == 4'hF) begin
            link.tx_line <= tx_shift[0];
            tx_bit       <= 3'h0;
            tx_state     <= EUHP_LN_DATA;
          end
        end
        EUHP_LN_DATA: begin
          if (tick && tx_os == 4'hF) begin
            if (tx_bit == 3'h7) begin
              link.tx_line <= 1'b1;
              tx_state     <= EUHP_LN_STOP;
            end else begin
              link.tx_line <= tx_shift[1];
              tx_shift     <= {1'b0, tx_shift[7:1]};
              tx_bit       <= tx_bit + 3'h1;
            end
          end
        end
        EUHP_LN_STOP: begin
          if (tick && tx_os == 4'hF) begin
            tx_state <= EUHP_LN_IDLE;
          end
        end
        default: tx_state <= EUHP_LN_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  logic       rx_s1;
  logic       rx_s2;
  logic       rx_prev;
  euhp_line_t rx_state;
  logic [3:0] rx_os;
  logic [2:0] rx_bit;
  logic [7:0] rx_shift;

  always_ff @(posedge clk_in) begin
    rx_s1 <= link.rx_line;
    rx_s2 <= rx_s1;
  end

  always_ff @(posedge clk_in) begin
    if (reset_in || core_rst) begin
      rx_prev          <= 1'b1;
      rx_state         <= EUHP_LN_IDLE;
      rx_os            <= 4'h0;
      rx_bit           <= 3'h0;
      rx_shift         <= 8'h00;
      rx_data_out      <= 8'h00;
      rx_valid_out     <= 1'b0;
      rx_frame_err_out <= 1'b0;
    end else begin
      rx_prev          <= rx_s2;
      rx_valid_out     <= 1'b0;
      rx_frame_err_out <= 1'b0;
      if (tick) begin
        rx_os <= rx_os + 4'h1;
      end
      case (rx_state)
        EUHP_LN_IDLE: begin
          if (rx_prev && !rx_s2) begin
            rx_os    <= 4'h0;
            rx_state <= EUHP_LN_START;
          end
        end
        EUHP_LN_START: begin
          if (tick && rx_os == 4'(`EUHP_HALF_BIT - 1)) begin
            rx_os  <= 4'h0;
            rx_bit <= 3'h0;
            // Glitch shorter than half a bit is dropped
            rx_state <= rx_s2 ? EUHP_LN_IDLE : EUHP_LN_DATA;
          end
        end
        EUHP_LN_DATA: begin
          if (tick && rx_os == 4'hF) begin
            rx_shift <= {rx_s2, rx_shift[7:1]};
            rx_bit   <= rx_bit + 3'h1;
            if (rx_bit == 3'h7) begin
              rx_state <= EUHP_LN_STOP;
            end
          end
        end
        EUHP_LN_STOP: begin
          if (tick && rx_os == 4'hF) begin
            rx_data_out      <= rx_shift;
            rx_valid_out     <= rx_s2;
            rx_frame_err_out <= !rx_s2;
            rx_state         <= EUHP_LN_IDLE;
          end
        end
        default: rx_state <= EUHP_LN_IDLE;
      endcase
    end
  end

endmodule

`default_nettype wire

// >>> hdl/euhp_host.sv
// Host end of the serial link with reset pin control
`timescale 1ns/1ps
`default_nettype none
`include "euhp_map.svh"

module euhp_host
  import euhp_pkg::*;
#(
  parameter int MCLK_KHZ = `EUHP_MCLK_KHZ,
  parameter int CLK_KHZ  = `EUHP_CLK_KHZ
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  // Link
  euhp_link_if.host        link,
  // Control
  input  wire logic        dev_reset_in,
  input  wire logic        div_load_in,
  input  wire logic [15:0] baud_div_in,
  // Transmit stream
  input  wire logic [7:0]  tx_data_in,
  input  wire logic        tx_valid_in,
  output logic             tx_ready_out,
  // Receive stream
  output logic [7:0]       rx_data_out,
  output logic             rx_valid_out,
  output logic             rx_frame_err_out
);

  // ----------------------------------------------------------------
  // Rate and device reset pin
  // ----------------------------------------------------------------
  logic [15:0] baud_div;
  logic [39:0] nco_acc;
  logic [40:0] nco_nxt;
  logic        tick;

  // Starts at the device default rate
  always_ff @(posedge clk_in) begin
    if (reset_in || dev_reset_in) begin
      baud_div <= `EUHP_DIV_DEFAULT;
    end else if (div_load_in && baud_div_in != 16'h0000) begin
      baud_div <= baud_div_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      link.reset_pin_n <= 1'b0;
    end else begin
      link.reset_pin_n <= !dev_reset_in;
    end
  end

  assign nco_nxt = euhp_nco_step(nco_acc, baud_div, 40'(MCLK_KHZ),
                                 40'(CLK_KHZ));

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      nco_acc <= 40'h0;
      tick    <= 1'b0;
    end else begin
      nco_acc <= nco_nxt[39:0];
      tick    <= nco_nxt[40];
    end
  end

  // ----------------------------------------------------------------
  // Transmitter: a 10-bit shift frame
  // ----------------------------------------------------------------
  logic [9:0] tx_frame;
  logic [3:0] tx_left;
  logic [3:0] tx_os;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      tx_frame     <= 10'h3FF;
      tx_left      <= 4'h0;
      tx_os        <= 4'h0;
      link.rx_line <= 1'b1;
      tx_ready_out <= 1'b0;
    end else begin
      tx_ready_out <= (tx_left == 4'h0) && !(tx_valid_in && tx_ready_out);
      if (tx_left == 4'h0) begin
        link.rx_line <= 1'b1;
        if (tx_valid_in && tx_ready_out) begin
          tx_frame <= {1'b1, tx_data_in, 1'b0};
          tx_left  <= 4'(`EUHP_FRAME_BITS + 1);
          tx_os    <= 4'h0;
        end
      end else if (tick) begin
        tx_os <= tx_os + 4'h1;
        // Start edge waits for a tick so the start bit is full length
        if (tx_left == 4'(`EUHP_FRAME_BITS + 1)) begin
          tx_left      <= 4'(`EUHP_FRAME_BITS);
          tx_os        <= 4'h0;
          link.rx_line <= 1'b0;
        end else if (tx_os == 4'hF) begin
          tx_frame     <= {1'b1, tx_frame[9:1]};
          tx_left      <= tx_left - 4'h1;
          link.rx_line <= (tx_left == 4'h1) ? 1'b1 : tx_frame[1];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  logic       rx_s1;
  logic       rx_s2;
  logic       rx_prev;
  logic [3:0] rx_left;
  logic [3:0] rx_os;
  logic [8:0] rx_shift;

  always_ff @(posedge clk_in) begin
    rx_s1 <= link.tx_line;
    rx_s2 <= rx_s1;
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rx_prev          <= 1'b1;
      rx_left          <= 4'h0;
      rx_os            <= 4'h0;
      rx_shift         <= 9'h000;
      rx_data_out      <= 8'h00;
      rx_valid_out     <= 1'b0;
      rx_frame_err_out <= 1'b0;
    end else begin
      rx_prev          <= rx_s2;
      rx_valid_out     <= 1'b0;
      rx_frame_err_out <= 1'b0;
      if (rx_left == 4'h0) begin
        if (rx_prev && !rx_s2) begin
          rx_left <= 4'(`EUHP_FRAME_BITS);
          rx_os   <= 4'(`EUHP_HALF_BIT);
        end
      end else if (tick) begin
        rx_os <= rx_os + 4'h1;
        if (rx_os == 4'hF) begin
          rx_left <= rx_left - 4'h1;
          if (rx_left == 4'(`EUHP_FRAME_BITS) && rx_s2) begin
            rx_left <= 4'h0;
          end
          rx_shift <= {rx_s2, rx_shift[8:1]};
          if (rx_left == 4'h1) begin
            rx_data_out      <= rx_shift[8:1];
            rx_valid_out     <= rx_s2;
            rx_frame_err_out <= !rx_s2;
          end
        end
      end
    end
  end

endmodule

`default_nettype wire

// >>> sim/euhp_link_chk.sv
// Checker for the two-wire link between device and host ends
`timescale 1ns/1ps
`default_nettype none

module euhp_link_chk #(
  parameter int BIT = 78
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic tx_line,
  input wire logic rx_line,
  input wire logic reset_pin_n
);
  // --------------------------------------------------------------
  // Frame trackers, index 1 is transmit and 0 is receive
  // --------------------------------------------------------------
  localparam int BMIN = BIT - 2;
  localparam int MID0 = BIT / 2;
  localparam int MIDS = BIT * 19 / 2;
  // Ends inside the stop bit so a back to back start is still seen
  localparam int FEND = BIT * 10 - 10;
  logic [1:0]  ln;
  logic [1:0]  ln_q;
  logic [11:0] run [2];
  logic [11:0] fc  [2];

  assign ln = {tx_line, rx_line};

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  always_ff @(posedge clk_in) begin
    ln_q <= reset_in ? 2'h3 : ln;
  end

  always_ff @(posedge clk_in) begin
    for (int i = 0; i < 2; i++) begin
      if (reset_in) begin
        run[i] <= 12'hFFF;
        fc[i]  <= 12'h000;
      end else begin
        run[i] <= (ln[i] != ln_q[i]) ? 12'h001
                : 12'(run[i] + 12'(run[i] != 12'hFFF));
        if (fc[i] == 12'h000) begin
          fc[i] <= 12'(ln_q[i] && !ln[i]);
        end else begin
          fc[i] <= (fc[i] == 12'(FEND)) ? 12'h000 : 12'(fc[i] + 12'h001);
        end
      end
    end
  end

  a_tx_bit_width: assert property ((ln[1] != ln_q[1]) |-> run[1] >= BMIN)
    else $error("transmit line bit shorter than one bit period");
  a_rx_bit_width: assert property ((ln[0] != ln_q[0]) |-> run[0] >= BMIN)
    else $error("receive line bit shorter than one bit period");
  a_tx_start_low: assert property (fc[1] == 12'(MID0) |-> !tx_line)
    else $error("transmit start bit not low at its centre");
  a_rx_start_low: assert property (fc[0] == 12'(MID0) |-> !rx_line)
    else $error("receive start bit not low at its centre");
  a_tx_stop_high: assert property (fc[1] == 12'(MIDS) |-> tx_line)
    else $error("transmit stop bit not high");
  a_rx_stop_high: assert property (fc[0] == 12'(MIDS) |-> rx_line)
    else $error("receive stop bit not high");
  a_idle_after_reset: assert property ($fell(reset_in) |-> tx_line && rx_line)
    else $error("link lines not idle high after reset");
  a_pin_released: assert property ($fell(reset_in) |=> reset_pin_n [*2])
    else $error("reset pin not released after host reset");

  c_tx_frame: cover property (fc[1] == 12'(MIDS));
  c_rx_frame: cover property (fc[0] == 12'(MIDS));
  c_pin_low:  cover property (!reset_pin_n [*8]);
endmodule

`default_nettype wire

// >>> sim/energy_ic_uart_host_port_tb.sv
// Self-checking bench joining device and host ends of the link
`timescale 1ns/1ps
`default_nettype none

module energy_ic_uart_host_port_tb;
  import euhp_pkg::*;
  // --------------------------------------------------------------
  // Stimulus, instances and monitors
  // --------------------------------------------------------------
  // Fast divisor keeps a frame near 781 cycles
  localparam logic [15:0] DIV = 16'h8000;
  localparam int          BIT = 78;
  logic        clk_in   = 1'b0;
  logic        reset_in = 1'b1;
  logic        cfg_load = 1'b0;
  logic        div_load = 1'b0;
  logic [15:0] div_val  = DIV;
  logic        gain_sel = 1'b0;
  logic [1:0]  do_func  = 2'h0;
  logic        mclk_ext = 1'b0;
  logic        dev_rst  = 1'b0;
  logic [3:0]  ev       = 4'h0;
  logic [7:0]  d_txd    = 8'h00;
  logic [7:0]  h_txd    = 8'h00;
  logic        d_txv    = 1'b0;
  logic        h_txv    = 1'b0;
  logic        d_txr, h_txr, d_rxv, h_rxv, d_rxe, h_rxe;
  logic        do_o, gain_o, mclk_o, run_o;
  logic [7:0]  d_rxd, h_rxd;
  logic [7:0]  d_q [$];
  logic [7:0]  h_q [$];
  int          err_count = 0;
  int          cmp_count = 0;
  int          ferr      = 0;

  initial forever #25 clk_in = ~clk_in;

  euhp_link_if u_euhp_link_if ();
  euhp_device u_euhp_device (
    .clk_in(clk_in), .reset_in(reset_in), .link(u_euhp_link_if.device),
    .cfg_load_in(cfg_load), .baud_div_in(div_val), .gain_sel_in(gain_sel),
    .do_func_in(do_func), .mclk_ext_in(mclk_ext), .tx_data_in(d_txd),
    .tx_valid_in(d_txv), .tx_ready_out(d_txr), .rx_data_out(d_rxd),
    .rx_valid_out(d_rxv), .rx_frame_err_out(d_rxe),
    .energy_pulse_in(ev[0]), .irq_in(ev[1]), .zero_cross_in(ev[2]),
    .energy_dir_in(ev[3]), .do_out(do_o), .gain_50x_out(gain_o),
    .mclk_ext_out(mclk_o), .running_out(run_o));
  euhp_host u_euhp_host (
    .clk_in(clk_in), .reset_in(reset_in), .link(u_euhp_link_if.host),
    .dev_reset_in(dev_rst), .div_load_in(div_load), .baud_div_in(div_val),
    .tx_data_in(h_txd), .tx_valid_in(h_txv), .tx_ready_out(h_txr),
    .rx_data_out(h_rxd), .rx_valid_out(h_rxv), .rx_frame_err_out(h_rxe));
  euhp_link_chk #(.BIT(BIT)) u_euhp_link_chk (
    .clk_in(clk_in), .reset_in(reset_in),
    .tx_line(u_euhp_link_if.tx_line), .rx_line(u_euhp_link_if.rx_line),
    .reset_pin_n(u_euhp_link_if.reset_pin_n));

  always @(negedge clk_in) begin
    if (d_rxv === 1'b1) d_q.push_back(d_rxd);
    if (h_rxv === 1'b1) h_q.push_back(h_rxd);
    if (d_rxe === 1'b1 || h_rxe === 1'b1) ferr++;
  end

  // --------------------------------------------------------------
  // Shared tasks and scenarios
  // --------------------------------------------------------------
  task automatic tally_and_finish();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic step(inout int n);
    @(negedge clk_in);
    n++;
    if (n > 40000) begin
      err_count++;
      $display("MISMATCH t=%0t wait limit reached", $time);
      tally_and_finish();
    end
  endtask

  task automatic load(input logic [15:0] d, input logic both);
    @(posedge clk_in);
    div_val  <= d;
    cfg_load <= 1'b1;
    div_load <= both;
    @(posedge clk_in);
    cfg_load <= 1'b0;
    div_load <= 1'b0;
  endtask

  // Samples the wire at each bit centre once the start bit shows
  task automatic line_check(input logic tx, input logic [7:0] b);
    logic [9:0] got;
    int         n;
    n = 0;
    while ((tx ? u_euhp_link_if.tx_line : u_euhp_link_if.rx_line) !== 1'b0)
      step(n);
    repeat (BIT / 2 - 1) @(negedge clk_in);
    for (int i = 0; i < 10; i++) begin
      got[i] = tx ? u_euhp_link_if.tx_line : u_euhp_link_if.rx_line;
      repeat (BIT) @(negedge clk_in);
    end
    chk8(got[8:1], b);
    chk8({6'h00, got[9], got[0]}, 8'h02);
  endtask

  // Mask bit 1 sends from device, bit 0 from host
  task automatic xfer(input logic [1:0] m, input logic [7:0] db,
                      input logic [7:0] hb);
    int n;
    n = 0;
    // Each end selected by the mask is ready first, so each valid lasts exactly one take
    while (({d_txr, h_txr} & m) !== m) step(n);
    @(posedge clk_in);
    d_txd <= db;
    h_txd <= hb;
    d_txv <= m[1];
    h_txv <= m[0];
    @(posedge clk_in);
    d_txv <= 1'b0;
    h_txv <= 1'b0;
    fork
      if (m[1]) line_check(1'b1, db);
      if (m[0]) line_check(1'b0, hb);
    join
    while (h_q.size() < int'(m[1]) || d_q.size() < int'(m[0])) step(n);
    if (m[1]) chk8(h_q.pop_front(), db);
    if (m[0]) chk8(d_q.pop_front(), hb);
  endtask

  task automatic t_setup();
    int n;
    n = 0;
    while (run_o !== 1'b1) step(n);
    chk8({6'h00, gain_o, mclk_o}, 8'h00);
    @(posedge clk_in);
    ev <= 4'h1;
    repeat (3) @(negedge clk_in);
    chk8({7'h00, do_o}, 8'h01);
    load(DIV, 1'b1);
    $display("Test setup done");
  endtask

  task automatic t_frames();
    logic [7:0] tbl [4] = '{8'h01, 8'h80, 8'hA5, 8'hFF};
    foreach (tbl[i]) begin
      xfer(2'h2, tbl[i], 8'h00);
      xfer(2'h1, 8'h00, tbl[i]);
    end
    $display("Test frames done");
  endtask

  task automatic t_duplex();
    xfer(2'h3, 8'h3C, 8'hC3);
    xfer(2'h3, 8'h00, 8'h7E);
    $display("Test duplex done");
  endtask

  task automatic t_outputs();
    for (int f = 0; f < 4; f++) begin
      @(posedge clk_in);
      gain_sel <= f[0];
      do_func  <= 2'(f);
      load(16'h0000, 1'b0);
      ev <= 4'(1 << f);
      repeat (3) @(negedge clk_in);
      chk8({6'h00, gain_o, do_o}, {6'h00, f[0], 1'b1});
      @(posedge clk_in);
      ev <= ~4'(1 << f);
      repeat (3) @(negedge clk_in);
      chk8({7'h00, do_o}, 8'h00);
    end
    // Zero divisor was refused, so the fast rate still holds
    xfer(2'h3, 8'h5A, 8'hA5);
    $display("Test outputs done");
  endtask

  task automatic t_dev_reset();
    int n;
    n = 0;
    @(posedge clk_in);
    dev_rst <= 1'b1;
    repeat (100) @(posedge clk_in);
    dev_rst <= 1'b0;
    repeat (4) @(negedge clk_in);
    chk8({7'h00, run_o}, 8'h01);
    @(posedge clk_in);
    dev_rst  <= 1'b1;
    mclk_ext <= 1'b1;
    repeat (2449) @(posedge clk_in);
    @(negedge clk_in);
    chk8({7'h00, run_o}, 8'h00);
    @(posedge clk_in);
    dev_rst <= 1'b0;
    while (run_o !== 1'b1) step(n);
    chk8({6'h00, gain_o, mclk_o}, 8'h01);
    $display("Test device reset done");
  endtask

  initial begin
    repeat (6) @(posedge clk_in);
    reset_in <= 1'b0;
    t_setup();
    t_frames();
    t_duplex();
    t_outputs();
    t_dev_reset();
    chk8(8'(ferr), 8'h00);
    tally_and_finish();
  end
endmodule

`default_nettype wire
